// ==== hw/iop_pkg.sv ====
// Package for the interrupt and output pin routing block.
// Assumes a single 100 MHz pclk domain and a 32-bit APB register port.
package iop_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0] IOP_OFS_STATUS = 8'h00;
  localparam logic [7:0] IOP_OFS_MASK = 8'h04;
  localparam logic [7:0] IOP_OFS_PIN_SEL = 8'h08;
  localparam logic [7:0] IOP_OFS_POLARITY = 8'h0c;
  localparam logic [7:0] IOP_OFS_RUN_LO = 8'h10;
  localparam logic [7:0] IOP_OFS_RUN_HI = 8'h14;
  localparam logic [7:0] IOP_OFS_RX_MODE = 8'h18;
  localparam logic [7:0] IOP_OFS_IRQ_STATE = 8'h1c;

  // Status bit positions; configuration A in the low nibble, B above it.
  localparam int IOP_BIT_WAKE = 0;
  localparam int IOP_BIT_FSYNC = 1;
  localparam int IOP_BIT_MSGID = 2;
  localparam int IOP_BIT_EOM = 3;
  localparam int IOP_CFG_STRIDE = 4;

  // Polarity register: per-pin invert bits, then the interrupt polarity.
  localparam int IOP_POL_IRQ_BIT = 4;

  // Values after reset.
  localparam logic [7:0] IOP_RST_STATUS = 8'hff;
  localparam logic [7:0] IOP_RST_MASK = 8'hff;
  localparam logic [15:0] IOP_RST_PIN_SEL = 16'h5210;
  localparam logic [4:0] IOP_RST_POLARITY = 5'h00;
  localparam logic [3:0] IOP_RST_RUN = 4'hf;
  localparam logic [3:0] IOP_RST_RX_MODE = 4'h0;

  // Output pin source codes, four bits per pin.
  localparam logic [3:0] IOP_SRC_CLK_OUT = 4'h0;
  localparam logic [3:0] IOP_SRC_RX_RUN = 4'h1;
  localparam logic [3:0] IOP_SRC_IRQ = 4'h2;
  localparam logic [3:0] IOP_SRC_LOW = 4'h3;
  localparam logic [3:0] IOP_SRC_HIGH = 4'h4;
  localparam logic [3:0] IOP_SRC_DATA = 4'h5;
  localparam logic [3:0] IOP_SRC_MF_DATA = 4'h6;
  localparam logic [3:0] IOP_SRC_CHIP_DATA = 4'h7;
  localparam logic [3:0] IOP_SRC_CHIP_STROBE = 4'h8;
  localparam logic [3:0] IOP_SRC_RXD = 4'h9;
  localparam logic [3:0] IOP_SRC_RXD_STROBE = 4'ha;
  localparam logic [3:0] IOP_SRC_LAST = 4'ha;

  // Receive mode codes; only the two framer modes report frame events.
  localparam logic [1:0] IOP_MODE_PACKET_TRANSPARENT = 2'h2;
  localparam logic [1:0] IOP_MODE_PACKET_FIFO = 2'h3;

  // Interrupt unit states after a reset event.
  typedef enum logic {IOP_IRQ_RESET_HELD, IOP_IRQ_NORMAL} iop_irq_state_e;

endpackage

// ==== hw/iop_route_if.sv ====
// Interface between the register core and the pin routing modules.
// Assumes all members live in the pclk domain.
`timescale 1ns/1ps
interface iop_route_if;
  logic [15:0] pin_sel;
  logic [3:0] pin_inv;
  logic [7:0] run_cfg;
  logic rx_run_a;
  logic rx_run_b;
  logic [3:0] rx_run_pin;
  logic irq_line;
  logic p_on;
  logic clk_out;
  logic sliced_data;
  logic matched_filter_data;
  logic chip_data;
  logic chip_strobe;
  logic recovered_data;
  logic recovered_data_strobe;

  modport core (output pin_sel, pin_inv, run_cfg, rx_run_a, rx_run_b,
    irq_line, p_on, clk_out, sliced_data, matched_filter_data, chip_data,
    chip_strobe, recovered_data, recovered_data_strobe);
  modport run (input run_cfg, rx_run_a, rx_run_b, output rx_run_pin);
  modport mux (input pin_sel, pin_inv, rx_run_pin, irq_line, p_on, clk_out,
    sliced_data, matched_filter_data, chip_data, chip_strobe,
    recovered_data, recovered_data_strobe);
endinterface

// ==== hw/iop_rx_run.sv ====
// Per-pin receiver-running signal built from the two configurations.
// Assumes the enables come from the register core in the same clock.
`timescale 1ns/1ps
module iop_rx_run
  import iop_pkg::*;
(
  iop_route_if.run rt
);

  // Each pin has an enable for configuration A and one for B.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rt.rx_run_pin[i] = (rt.rx_run_a & rt.run_cfg[2*i]) |
                         (rt.rx_run_b & rt.run_cfg[2*i+1]);
    end
  end

endmodule // iop_rx_run

// ==== hw/iop_pin_mux.sv ====
// Source selection, inversion and tri-state control of the output pins.
// Assumes synchronous sources; the pin level is registered once.
`timescale 1ns/1ps
module iop_pin_mux
  import iop_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  iop_route_if.mux rt,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe
);

  // Picks one routed source for a pin from its four-bit code.
  function automatic logic pick(input logic [3:0] sel, input int pin);
    case (sel)
      IOP_SRC_CLK_OUT: pick = rt.clk_out;
      IOP_SRC_RX_RUN: pick = rt.rx_run_pin[pin];
      IOP_SRC_IRQ: pick = rt.irq_line;
      IOP_SRC_LOW: pick = 1'b0;
      IOP_SRC_HIGH: pick = 1'b1;
      IOP_SRC_DATA: pick = rt.sliced_data;
      IOP_SRC_MF_DATA: pick = rt.matched_filter_data;
      IOP_SRC_CHIP_DATA: pick = rt.chip_data;
      IOP_SRC_CHIP_STROBE: pick = rt.chip_strobe;
      IOP_SRC_RXD: pick = rt.recovered_data;
      IOP_SRC_RXD_STROBE: pick = rt.recovered_data_strobe;
      default: pick = 1'b0;
    endcase
  endfunction

  // Pins float whenever the power-on input is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 4'h0;
      pin_oe <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        pin_out[i] <= rt.p_on &
          (pick(rt.pin_sel[4*i +: 4], i) ^ rt.pin_inv[i]);
        pin_oe[i] <= rt.p_on;
      end
    end
  end

endmodule // iop_pin_mux

// ==== hw/iop_top.sv ====
// Interrupt generation and output pin routing with an APB register port.
// Assumes one 100 MHz pclk, synchronous event pulses and an APB master.
//
// Contract
// - Power-on input low puts every digital output pin in high impedance.
// - Each of four pins selects one of eleven documented signal sources.
// - Clock output cannot be routed to the fourth pin.
// - Every output pin has its own inversion control.
// - Receiver-running defaults active for both configurations, per-pin enables.
// - Interrupt output asserts only for sources enabled in the mask.
// - Each interrupt event sets its own status bit.
// - Interrupt polarity is programmable except while reset holds it.
// - Reset event wins: all status bits one, interrupt signal zero.
// - First event after reset clears status, drives interrupt to one.
// - Wake-up clears both frame-sync flags and the other wake-up flag.
// - Frame-sync clears end, message-ID flags and other frame-sync flag.
// - Reading the status register clears it.
// - Reset indicator interrupt ignores the mask register.
// - Frame-sync, message-ID, end events count only in framer modes.
// - Status content is captured when the read address is taken.
// - Status clears after the read completes; events between are lost.
// - Unmasked events during a status read still move the interrupt.
`timescale 1ns/1ps
module iop_top
  import iop_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic por_event,
  input wire logic [1:0] wakeup_event,
  input wire logic [1:0] frame_sync_event,
  input wire logic [1:0] msg_id_event,
  input wire logic [1:0] end_of_message_event,
  input wire logic rx_run_a,
  input wire logic rx_run_b,
  input wire logic p_on,
  input wire logic clk_out,
  input wire logic sliced_data,
  input wire logic matched_filter_data,
  input wire logic chip_data,
  input wire logic chip_strobe,
  input wire logic recovered_data,
  input wire logic recovered_data_strobe,
  output logic [3:0] config_out_pin,
  output logic [3:0] config_out_pin_oe
);

  iop_route_if rt ();

  // Register state.
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] irq_mask_reg_q;
  logic [15:0] pin_sel_q;
  logic [4:0] pin_polarity_cfg_q;
  logic [3:0] rx_running_cfg_lo_q;
  logic [3:0] rx_running_cfg_hi_q;
  logic [3:0] rx_mode_q;
  logic [31:0] prdata_q;
  iop_irq_state_e irq_state_q;
  logic irq_active_q;
  logic irq_line_q;

  // Bus decode.
  logic setup_rd;
  logic access_wr;
  logic access_rd;
  logic addr_ok;
  logic status_clear;

  // Event vectors.
  logic framer_a;
  logic framer_b;
  logic [7:0] ev_vec;
  logic [7:0] cross_clr;
  logic any_event;
  logic irq_raw;

  // Tells whether an address hits one of the mapped registers.
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      IOP_OFS_STATUS, IOP_OFS_MASK, IOP_OFS_PIN_SEL, IOP_OFS_POLARITY,
      IOP_OFS_RUN_LO, IOP_OFS_RUN_HI, IOP_OFS_RX_MODE,
      IOP_OFS_IRQ_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Tells whether a receive mode runs the framer.
  function automatic logic is_framer(input logic [1:0] m);
    is_framer = (m == IOP_MODE_PACKET_TRANSPARENT) ||
                (m == IOP_MODE_PACKET_FIFO);
  endfunction

  // Keeps the old routing of a pin when the new code is not allowed there.
  function automatic logic [3:0] sel_field(input logic [3:0] new_sel,
                                           input logic [3:0] old_sel,
                                           input int pin);
    if (new_sel > IOP_SRC_LAST) begin
      sel_field = old_sel;
    end else if (pin == 3 && new_sel == IOP_SRC_CLK_OUT) begin
      sel_field = old_sel;
    end else begin
      sel_field = new_sel;
    end
  endfunction

  // The slave always answers in the access cycle, so no wait states.
  // Refused accesses still complete at once; only pslverr marks them.
  assign pready = 1'b1;
  assign addr_ok = mapped(paddr);
  assign pslverr = psel & penable & ~addr_ok;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign access_wr = psel & penable & pwrite & addr_ok;
  assign access_rd = psel & penable & ~pwrite;
  assign prdata = prdata_q;

  // Clear lands at the completing edge of a status read, after capture.
  assign status_clear = access_rd & (paddr == IOP_OFS_STATUS);

  // Frame events are dropped unless that configuration runs the framer.
  assign framer_a = is_framer(rx_mode_q[1:0]);
  assign framer_b = is_framer(rx_mode_q[3:2]);

  // Gathered event vector in status layout.
  always_comb begin
    ev_vec = 8'h00;
    ev_vec[IOP_BIT_WAKE] = wakeup_event[0];
    ev_vec[IOP_BIT_FSYNC] = frame_sync_event[0] & framer_a;
    ev_vec[IOP_BIT_MSGID] = msg_id_event[0] & framer_a;
    ev_vec[IOP_BIT_EOM] = end_of_message_event[0] & framer_a;
    ev_vec[IOP_CFG_STRIDE + IOP_BIT_WAKE] = wakeup_event[1];
    ev_vec[IOP_CFG_STRIDE + IOP_BIT_FSYNC] = frame_sync_event[1] & framer_b;
    ev_vec[IOP_CFG_STRIDE + IOP_BIT_MSGID] = msg_id_event[1] & framer_b;
    ev_vec[IOP_CFG_STRIDE + IOP_BIT_EOM] =
      end_of_message_event[1] & framer_b;
  end

  assign any_event = |ev_vec;

  // Cross-clearing between the two configurations.
  always_comb begin
    cross_clr = 8'h00;
    for (int c = 0; c < 2; c++) begin
      if (ev_vec[c*IOP_CFG_STRIDE + IOP_BIT_WAKE]) begin
        cross_clr[IOP_BIT_FSYNC] = 1'b1;
        cross_clr[IOP_CFG_STRIDE + IOP_BIT_FSYNC] = 1'b1;
        cross_clr[(1-c)*IOP_CFG_STRIDE + IOP_BIT_WAKE] = 1'b1;
      end
      if (ev_vec[c*IOP_CFG_STRIDE + IOP_BIT_FSYNC]) begin
        cross_clr[IOP_BIT_EOM] = 1'b1;
        cross_clr[IOP_CFG_STRIDE + IOP_BIT_EOM] = 1'b1;
        cross_clr[IOP_BIT_MSGID] = 1'b1;
        cross_clr[IOP_CFG_STRIDE + IOP_BIT_MSGID] = 1'b1;
        cross_clr[(1-c)*IOP_CFG_STRIDE + IOP_BIT_FSYNC] = 1'b1;
      end
    end
  end

  // Next status value; a new event beats a cross-clear of its own bit.
  // A read clear wins over everything but a reset event, which loses events in the read.
  always_comb begin
    if (por_event) begin
      status_d = IOP_RST_STATUS;
    end else if (status_clear) begin
      status_d = 8'h00;
    end else if (irq_state_q == IOP_IRQ_RESET_HELD && any_event) begin
      status_d = ev_vec;
    end else begin
      status_d = (status_q & ~cross_clr) | ev_vec;
    end
  end

  // Status register.
  // In status and interrupt state, the chip reset looks to software exactly like a reset event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= IOP_RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // Reset tracking: held until the first event, whatever the mask says.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_state_q <= IOP_IRQ_RESET_HELD;
    end else if (por_event) begin
      irq_state_q <= IOP_IRQ_RESET_HELD;
    end else if (any_event) begin
      irq_state_q <= IOP_IRQ_NORMAL;
    end
  end

  // The raw request also looks at this cycle's events, so an unmasked
  // event still moves the line even when a read clear discards its bit.
  assign irq_raw = |((status_d | ev_vec) & ~irq_mask_reg_q);

  // Raw request kept for software; a reset event drops it at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_active_q <= 1'b0;
    end else if (por_event) begin
      irq_active_q <= 1'b0;
    end else begin
      irq_active_q <= irq_raw;
    end
  end

  // Interrupt line level; while reset holds it, the line sits at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_line_q <= 1'b0;
    end else if (por_event) begin
      irq_line_q <= 1'b0;
    end else if (irq_state_q == IOP_IRQ_RESET_HELD && !any_event) begin
      irq_line_q <= 1'b0;
    end else if (irq_state_q == IOP_IRQ_RESET_HELD) begin
      irq_line_q <= 1'b1;
    end else begin
      // Polarity bit set means active high; clear means active low.
      irq_line_q <= pin_polarity_cfg_q[IOP_POL_IRQ_BIT] ?
                    irq_raw : ~irq_raw;
    end
  end

  // Interrupt mask; a set bit blocks its source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg_q <= IOP_RST_MASK;
    end else if (access_wr && paddr == IOP_OFS_MASK) begin
      irq_mask_reg_q <= pwdata[7:0];
    end
  end

  // Pin routing codes; illegal codes leave the old routing in place.
  // So a pin never lands on an unlisted source or clock on the fourth pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sel_q <= IOP_RST_PIN_SEL;
    end else if (access_wr && paddr == IOP_OFS_PIN_SEL) begin
      for (int i = 0; i < 4; i++) begin
        pin_sel_q[4*i +: 4] <= sel_field(pwdata[4*i +: 4],
                                         pin_sel_q[4*i +: 4], i);
      end
    end
  end

  // Pin inversion and interrupt polarity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_polarity_cfg_q <= IOP_RST_POLARITY;
    end else if (access_wr && paddr == IOP_OFS_POLARITY) begin
      pin_polarity_cfg_q <= pwdata[4:0];
    end
  end

  // Receiver-running enables, two pins per register, active by default.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_running_cfg_lo_q <= IOP_RST_RUN;
      rx_running_cfg_hi_q <= IOP_RST_RUN;
    end else if (access_wr && paddr == IOP_OFS_RUN_LO) begin
      rx_running_cfg_lo_q <= pwdata[3:0];
    end else if (access_wr && paddr == IOP_OFS_RUN_HI) begin
      rx_running_cfg_hi_q <= pwdata[3:0];
    end
  end

  // Receive mode of each configuration.
  // Codes 0 and 1 run no framer, so frame events are then dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_mode_q <= IOP_RST_RX_MODE;
    end else if (access_wr && paddr == IOP_OFS_RX_MODE) begin
      rx_mode_q <= pwdata[3:0];
    end
  end

  // Read data is captured in the setup cycle, which is also the moment
  // the status content is frozen for the reader.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_rd) begin
      case (paddr)
        IOP_OFS_STATUS: prdata_q <= {24'h00_0000, status_q};
        IOP_OFS_MASK: prdata_q <= {24'h00_0000, irq_mask_reg_q};
        IOP_OFS_PIN_SEL: prdata_q <= {16'h0000, pin_sel_q};
        IOP_OFS_POLARITY: prdata_q <= {27'h000_0000, pin_polarity_cfg_q};
        IOP_OFS_RUN_LO: prdata_q <= {28'h000_0000, rx_running_cfg_lo_q};
        IOP_OFS_RUN_HI: prdata_q <= {28'h000_0000, rx_running_cfg_hi_q};
        IOP_OFS_RX_MODE: prdata_q <= {28'h000_0000, rx_mode_q};
        IOP_OFS_IRQ_STATE: prdata_q <= {29'h0000_0000, irq_active_q,
          (irq_state_q == IOP_IRQ_RESET_HELD), irq_line_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Routing interface drivers.
  // Sources pass straight through; the pin mux registers them once.
  assign rt.pin_sel = pin_sel_q;
  assign rt.pin_inv = pin_polarity_cfg_q[3:0];
  assign rt.run_cfg = {rx_running_cfg_hi_q, rx_running_cfg_lo_q};
  assign rt.rx_run_a = rx_run_a;
  assign rt.rx_run_b = rx_run_b;
  assign rt.irq_line = irq_line_q;
  assign rt.p_on = p_on;
  assign rt.clk_out = clk_out;
  assign rt.sliced_data = sliced_data;
  assign rt.matched_filter_data = matched_filter_data;
  assign rt.chip_data = chip_data;
  assign rt.chip_strobe = chip_strobe;
  assign rt.recovered_data = recovered_data;
  assign rt.recovered_data_strobe = recovered_data_strobe;

  // Per-pin receiver-running combination.
  iop_rx_run iop_rx_run_inst (
    .rt(rt.run)
  );

  // Output pin multiplexer with inversion and tri-state control.
  iop_pin_mux iop_pin_mux_inst (
    .pclk(pclk),
    .presetn(presetn),
    .rt(rt.mux),
    .pin_out(config_out_pin),
    .pin_oe(config_out_pin_oe)
  );

endmodule // iop_top

// ==== dv/iop_top_chk.sv ====
// Checker for the interrupt and pin routing top, bound onto its ports.
// Assumes one pclk domain and the reset values of mask, routing, polarity.
`timescale 1ns/1ps
module iop_top_chk
  import iop_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic por_event,
  input wire logic [1:0] wakeup_event,
  input wire logic [1:0] frame_sync_event,
  input wire logic [1:0] msg_id_event,
  input wire logic [1:0] end_of_message_event,
  input wire logic p_on,
  input wire logic clk_out,
  input wire logic sliced_data,
  input wire logic [3:0] config_out_pin,
  input wire logic [3:0] config_out_pin_oe
);
  logic cfg_def_q;
  logic held_q;
  logic quiet_q;
  logic st_setup;
  logic st_done;
  logic any_ev;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Status read phases and any event at all.
  assign st_setup = psel && !penable && !pwrite && paddr == IOP_OFS_STATUS;
  assign st_done = psel && penable && !pwrite && paddr == IOP_OFS_STATUS;
  assign any_ev = |{wakeup_event, frame_sync_event, msg_id_event,
    end_of_message_event};

  // Any write to mask, routing or polarity ends the reset setup; a write of
  // the same value also ends it, which only costs coverage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_def_q <= 1'b1;
    end else if (psel && penable && pwrite && paddr inside
        {IOP_OFS_MASK, IOP_OFS_PIN_SEL, IOP_OFS_POLARITY}) begin
      cfg_def_q <= 1'b0;
    end
  end

  // Reset-held state; only wake-up leaves it, as it counts in every mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_q <= 1'b1;
    end else if (por_event) begin
      held_q <= 1'b1;
    end else if (|wakeup_event) begin
      held_q <= 1'b0;
    end
  end

  // Status known empty: set by a completed read, lost on any event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= 1'b0;
    end else if (por_event) begin
      quiet_q <= 1'b0;
    end else if (st_done) begin
      quiet_q <= 1'b1;
    end else if (any_ev) begin
      quiet_q <= 1'b0;
    end
  end

  pins_off_a: assert property (
    !p_on |=> config_out_pin_oe == 4'h0 && config_out_pin == 4'h0)
    else $error("pins driven while power-on input low");
  pins_on_a: assert property (
    p_on |=> config_out_pin_oe == 4'hf)
    else $error("pins not driven while power-on input high");
  clk_route_a: assert property (
    cfg_def_q |=> config_out_pin[0] == ($past(p_on) & $past(clk_out)))
    else $error("pin 0 does not follow clock output");
  data_route_a: assert property (
    cfg_def_q |=> config_out_pin[3] == ($past(p_on) & $past(sliced_data)))
    else $error("pin 3 does not follow sliced data");
  reset_irq_low_a: assert property (
    por_event && cfg_def_q ##1 cfg_def_q && !any_ev |=> !config_out_pin[2])
    else $error("interrupt pin not low after reset event");
  first_event_a: assert property (
    held_q && |wakeup_event && !por_event && cfg_def_q ##1 cfg_def_q && p_on
    && !por_event |=> config_out_pin[2])
    else $error("first event after reset did not raise interrupt");
  masked_idle_a: assert property (
    !held_q && cfg_def_q && p_on && !por_event |=> config_out_pin[2])
    else $error("active-low interrupt asserted with all sources masked");
  read_clear_a: assert property (
    st_setup && quiet_q |=> prdata == 32'h0)
    else $error("status not empty after a read with no event since");
  bad_addr_a: assert property (
    psel && penable && (paddr > IOP_OFS_IRQ_STATE || paddr[1:0] != 2'h0)
    |-> pslverr)
    else $error("unmapped address not refused");
endmodule // iop_top_chk

bind iop_top iop_top_chk iop_top_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .por_event(por_event), .wakeup_event(wakeup_event),
  .frame_sync_event(frame_sync_event), .msg_id_event(msg_id_event),
  .end_of_message_event(end_of_message_event), .p_on(p_on),
  .clk_out(clk_out), .sliced_data(sliced_data),
  .config_out_pin(config_out_pin), .config_out_pin_oe(config_out_pin_oe)
);

// ==== dv/iop_mcu_model.sv ====
// Application controller's view of the four configurable output pins.
// Assumes no pull resistor on the pins, so an undriven pin floats.
`timescale 1ns/1ps
module iop_mcu_model (
  input wire logic pclk,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  output logic [3:0] pin_level
);
  logic [3:0] last_q = 4'h0;

  // A floating pin shows the inverse of its last level, so it can never
  // pass for a driven one by the simulator's choice.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ~last_q[i];
    end
  end

  // Level seen at each edge.
  always_ff @(posedge pclk) begin
    last_q <= pin_level;
  end
endmodule // iop_mcu_model

// ==== dv/iop_top_test.sv ====
// Self-checking bench for the interrupt and pin routing top.
// Assumes a zero-wait APB slave and the pin model on the outputs.
`timescale 1ns/1ps
module iop_top_test;
  import iop_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [8:0] ev = 9'h0;
  logic [6:0] src = 7'b1010101;
  logic p_on = 1'b1;
  logic run_a = 1'b1;
  logic run_b = 1'b0;
  logic [3:0] pin;
  logic [3:0] oe;
  logic [3:0] level;
  logic [31:0] r;
  logic e;
  logic hit;
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] rst [7] = '{32'hff, 32'hff, 32'h5210, 32'h0, 32'hf, 32'hf,
    32'h0};
  localparam logic [10:0] TAB = 11'b10101010011;

  always #5 pclk = ~pclk;

  iop_top iop_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_event(ev[8]), .end_of_message_event(ev[7:6]),
    .msg_id_event(ev[5:4]), .frame_sync_event(ev[3:2]),
    .wakeup_event(ev[1:0]), .rx_run_a(run_a), .rx_run_b(run_b),
    .p_on(p_on), .clk_out(src[0]), .sliced_data(src[1]),
    .matched_filter_data(src[2]), .chip_data(src[3]),
    .chip_strobe(src[4]), .recovered_data(src[5]),
    .recovered_data_strobe(src[6]), .config_out_pin(pin),
    .config_out_pin_oe(oe));

  iop_mcu_model iop_mcu_model_inst (.pclk(pclk), .pin_out(pin),
    .pin_oe(oe), .pin_level(level));

  // One APB transfer; holds the request until pready is seen high.
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic err;
    xfer(1'b1, a, d, q, err);
  endtask

  // Single reads only, never a burst ending below the status register.
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic err;
    xfer(1'b0, a, 32'h0, q, err);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk(q, exp);
  endtask

  // One-cycle event pulse; callers run settle after it only before checking the line or pin.
  task automatic pulse(input logic [8:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 9'h0;
  endtask

  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cut a hang short well beyond the few hundred cycles needed.
  initial begin
    #200000;
    n_mismatch++;
    results();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Let the default routes of pins 0 and 3 see both levels once.
    @(posedge pclk) src <= ~src;
    @(posedge pclk) src <= ~src;
    pulse(9'h100);
    settle();
    chk(32'(pin[2]), 32'h0);
    rd(IOP_OFS_IRQ_STATE, r);
    chk(32'(r[1:0]), 32'h2);
    for (int i = 0; i < 7; i++) rdchk(8'(4 * i), rst[i]);
    rdchk(IOP_OFS_STATUS, 32'h0);
    xfer(1'b0, 8'h20, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("test reset done");
    pulse(9'h001);
    settle();
    chk(32'(pin[2]), 32'h1);
    rdchk(IOP_OFS_STATUS, 32'h01);
    wr(IOP_OFS_RX_MODE, 32'hf);
    pulse(9'h0f0);
    pulse(9'h002);
    pulse(9'h004);
    rdchk(IOP_OFS_STATUS, 32'h12);
    pulse(9'h002);
    pulse(9'h008);
    pulse(9'h001);
    rdchk(IOP_OFS_STATUS, 32'h01);
    wr(IOP_OFS_RX_MODE, 32'h0);
    pulse(9'h0fc);
    pulse(9'h002);
    rdchk(IOP_OFS_STATUS, 32'h10);
    wr(IOP_OFS_RX_MODE, 32'h2);
    pulse(9'h0c0);
    rdchk(IOP_OFS_STATUS, 32'h08);
    $display("test status done");
    wr(IOP_OFS_MASK, 32'hfe);
    wr(IOP_OFS_POLARITY, 32'h10);
    settle();
    chk(32'(pin[2]), 32'h0);
    pulse(9'h001);
    settle();
    chk(32'(pin[2]), 32'h1);
    rdchk(IOP_OFS_STATUS, 32'h01);
    pulse(9'h002);
    settle();
    chk(32'(pin[2]), 32'h0);
    rdchk(IOP_OFS_STATUS, 32'h10);
    hit = 1'b0;
    // The event lands on the clearing edge of the read, so its bit is lost.
    fork
      rd(IOP_OFS_STATUS, r);
      begin
        @(posedge pclk);
        pulse(9'h001);
      end
      repeat (6) begin
        @(posedge pclk);
        #1 hit |= pin[2];
      end
    join
    chk(r, 32'h0);
    chk(32'(hit), 32'h1);
    rdchk(IOP_OFS_STATUS, 32'h0);
    $display("test interrupt done");
    @(posedge pclk);
    p_on <= 1'b0;
    settle();
    chk({24'h0, oe, pin}, 32'h0);
    @(posedge pclk);
    p_on <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      wr(IOP_OFS_POLARITY, 32'h10 | 32'(v));
      for (int c = 0; c <= 10; c++) begin
        wr(IOP_OFS_PIN_SEL, 32'h5210 | 32'(c));
        settle();
        chk(32'(level[0]), 32'(TAB[c] ^ v[0]));
      end
    end
    wr(IOP_OFS_PIN_SEL, 32'h021b);
    rdchk(IOP_OFS_PIN_SEL, 32'h521a);
    wr(IOP_OFS_POLARITY, 32'h10);
    wr(IOP_OFS_PIN_SEL, 32'h5211);
    settle();
    chk(32'(level[0]), 32'h1);
    wr(IOP_OFS_RUN_LO, 32'he);
    settle();
    chk(32'(level[0]), 32'h0);
    @(posedge pclk);
    run_b <= 1'b1;
    settle();
    chk(32'(level[0]), 32'h1);
    $display("test pins done");
    pulse(9'h100);
    settle();
    chk(32'(pin[2]), 32'h0);
    rdchk(IOP_OFS_STATUS, 32'hff);
    $display("test second reset done");
    results();
  end
endmodule // iop_top_test
